// File: design/ttm_monitor.v
// Thermal throttle monitor: duty measurement, averaging, status flags and throttle drive.
// Assumes inputs synchronous-capable APB master and an open-drain throttle line pulled up.
//
// Contract
// - Measure asserted share per interval, 8 bits
// - Load measurement into current at interval end
// - Average becomes (old average + previous current)/2
// - Host write of current restarts capture
// - Zero only if never asserted; else nonzero
// - Full flag when asserted whole interval
// - 75 flag: value>=193 and not full
// - 50 flag: 129 <= value < 193
// - 25 flag: 65 <= value < 129
// - 12.5 flag: 33 <= value < 65
// - Low flag below 33 (code sets it only for values 1 to 32); any flag nonzero
// - User flag when value exceeds limit
// - Sleep: stop, current zero, average held
// - After sleep first result loads both
// - Drive line low on regulator overtemp
// - Suppress overtemp drive in sleep or disabled
// - Override register drives PWM onto line
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ttm_regs.vh"

module ttm_monitor #(
  parameter CW = 32
) (
  // Clock and reset.
  input  wire        MCLK_I,
  input  wire        RST_N_I,
  // APB slave.
  input  wire        PSEL_I,
  input  wire        PENABLE_I,
  input  wire        PWRITE_I,
  input  wire [11:0] PADDR_I,
  input  wire [31:0] PWDATA_I,
  output reg  [31:0] PRDATA_O,
  output wire        PREADY_O,
  output wire        PSLVERR_O,
  // Throttle line (open drain, active low) and regulator overtemp (active low).
  input  wire        THERMAL_THROTTLE_LINE_N_I,
  output wire        THERMAL_THROTTLE_LINE_O,
  output wire        THERMAL_THROTTLE_LINE_OE_N_O,
  input  wire        REGULATOR_OVERTEMP_INPUT_N_I
);

  // Registers.
  reg [CW-1:0] interval_q;
  reg [7:0]    current_q;
  reg [7:0]    average_q;
  reg [7:0]    limit_q;
  reg [7:0]    status_q;
  reg          ot_en_q;
  reg [15:0]   override_q;
  reg [1:0]    sleep_q;
  // Measurement state.
  reg [CW-1:0] tick_q;
  reg [CW-1:0] hits_q;
  reg          never_rel_q;
  reg          first_q;
  reg [7:0]    pwm_cnt_q;
  // Synchronisers.
  reg          thr_s1_q;
  reg          thr_s2_q;
  reg          ot_s1_q;
  reg          ot_s2_q;

  wire       wr_en   = PSEL_I & PENABLE_I & PWRITE_I;
  wire       asleep  = (sleep_q != `TTM_SLP_S0);
  wire       thr_act = ~thr_s2_q;
  wire       iv_end  = ~asleep & (tick_q >= interval_q - {{(CW-1){1'b0}}, 1'b1});
  wire       wr_cur  = wr_en & (PADDR_I == `TTM_OFF_CURRENT);
  wire       full_now = never_rel_q & thr_act;
  wire [CW-1:0] hits_fin = hits_q + {{(CW-1){1'b0}}, thr_act};
  // Nine-bit sum so the carry survives the halving.
  wire [8:0] avg_sum = {1'b0, average_q} + {1'b0, current_q};
  wire [7:0] duty;
  reg  [7:0] flags;

  // Zero-wait APB: every access completes in its first access cycle.
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = 1'b0;

  ttm_duty_scale #(.CW(CW)) u_scale (
    .hits_i (hits_fin),
    .span_i (interval_q),
    .duty_o (duty)
  );

  // Two-flop synchronisers; only the second stage is looked at.
  always @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      thr_s1_q <= 1'b1;
      thr_s2_q <= 1'b1;
      ot_s1_q  <= 1'b1;
      ot_s2_q  <= 1'b1;
    end else begin
      thr_s1_q <= THERMAL_THROTTLE_LINE_N_I;
      thr_s2_q <= thr_s1_q;
      ot_s1_q  <= REGULATOR_OVERTEMP_INPUT_N_I;
      ot_s2_q  <= ot_s1_q;
    end
  end

  // Status decode from a finished measurement.
  always @* begin
    flags = 8'h00;
    flags[`TTM_ST_FULL] = full_now;
    flags[`TTM_ST_P75]  = (duty >= `TTM_TH_75) & ~full_now;
    flags[`TTM_ST_P50]  = (duty >= `TTM_TH_50) & (duty < `TTM_TH_75);
    flags[`TTM_ST_P25]  = (duty >= `TTM_TH_25) & (duty < `TTM_TH_50);
    flags[`TTM_ST_P12]  = (duty >= `TTM_TH_12) & (duty < `TTM_TH_25);
    flags[`TTM_ST_P0]   = (duty != 8'h00) & (duty < `TTM_TH_12);
    flags[`TTM_ST_ANY]  = (duty != 8'h00);
    flags[`TTM_ST_USER] = (duty > limit_q);
  end

  // Software-written configuration.
  always @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      interval_q <= `TTM_RST_INTERVAL;
      limit_q    <= `TTM_RST_LIMIT;
      ot_en_q    <= `TTM_RST_CONTROL;
      override_q <= 16'h0000;
      sleep_q    <= `TTM_SLP_S0;
    end else if (wr_en) begin
      case (PADDR_I)
        `TTM_OFF_INTERVAL: begin
          // A zero interval would never end; clamp to one cycle.
          if (PWDATA_I[CW-1:0] == {CW{1'b0}})
            interval_q <= {{(CW-1){1'b0}}, 1'b1};
          else
            interval_q <= PWDATA_I[CW-1:0];
        end
        `TTM_OFF_LIMIT:    limit_q    <= PWDATA_I[7:0];
        `TTM_OFF_CONTROL:  ot_en_q    <= PWDATA_I[`TTM_CTL_OT_EN];
        `TTM_OFF_OVERRIDE: override_q <= PWDATA_I[15:0];
        `TTM_OFF_SLEEP:    sleep_q    <= PWDATA_I[1:0];
        default: ;
      endcase
    end
  end

  // Interval counting, capture, averaging and sleep handling.
  always @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      tick_q      <= {CW{1'b0}};
      hits_q      <= {CW{1'b0}};
      never_rel_q <= 1'b1;
      first_q     <= 1'b0;
      current_q   <= 8'h00;
      average_q   <= 8'h00;
      status_q    <= 8'h00;
    end else if (asleep) begin
      // Monitoring halts; the average is left alone for resume.
      tick_q      <= {CW{1'b0}};
      hits_q      <= {CW{1'b0}};
      never_rel_q <= 1'b1;
      first_q     <= 1'b1;
      current_q   <= 8'h00;
    end else if (wr_cur) begin
      // Host write abandons the running interval and stores the value.
      current_q   <= PWDATA_I[7:0];
      tick_q      <= {CW{1'b0}};
      hits_q      <= {CW{1'b0}};
      never_rel_q <= 1'b1;
    end else if (iv_end) begin
      current_q   <= duty;
      status_q    <= flags;
      first_q     <= 1'b0;
      if (first_q)
        average_q <= duty;
      else
        average_q <= avg_sum[8:1];
      tick_q      <= {CW{1'b0}};
      hits_q      <= {CW{1'b0}};
      never_rel_q <= 1'b1;
    end else begin
      tick_q      <= tick_q + {{(CW-1){1'b0}}, 1'b1};
      hits_q      <= hits_fin;
      never_rel_q <= full_now;
    end
  end

  // Override PWM: low byte is the low-time share out of a 256-cycle frame.
  always @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I)
      pwm_cnt_q <= 8'h00;
    else
      pwm_cnt_q <= pwm_cnt_q + 8'h01;
  end

  // Drive low on overtemp (two-cycle latency, far inside the response limit) or PWM.
  wire ot_drive  = ~ot_s2_q & ot_en_q & ~asleep;
  wire pwm_drive = override_q[8] & (pwm_cnt_q < override_q[7:0]);
  assign THERMAL_THROTTLE_LINE_O      = 1'b0;
  assign THERMAL_THROTTLE_LINE_OE_N_O = ~(ot_drive | pwm_drive);

  // Read data is registered so it is stable in the access phase.
  always @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I)
      PRDATA_O <= 32'h00000000;
    else if (PSEL_I & ~PENABLE_I & ~PWRITE_I) begin
      case (PADDR_I)
        `TTM_OFF_INTERVAL: PRDATA_O <= interval_q;
        `TTM_OFF_CURRENT:  PRDATA_O <= {24'h000000, current_q};
        `TTM_OFF_AVERAGE:  PRDATA_O <= {24'h000000, average_q};
        `TTM_OFF_LIMIT:    PRDATA_O <= {24'h000000, limit_q};
        `TTM_OFF_STATUS:   PRDATA_O <= {24'h000000, status_q};
        `TTM_OFF_CONTROL:  PRDATA_O <= {31'h00000000, ot_en_q};
        `TTM_OFF_OVERRIDE: PRDATA_O <= {16'h0000, override_q};
        `TTM_OFF_SLEEP:    PRDATA_O <= {30'h00000000, sleep_q};
        default:           PRDATA_O <= 32'h00000000;
      endcase
    end
  end

endmodule // ttm_monitor

`default_nettype wire

// File: design/ttm_regs.vh
// Register map, field positions, reset values and timing counts for the throttle monitor.
// Assumes a 125 MHz clock and a 32-bit APB slave with word-aligned registers.
`ifndef TTM_REGS_VH
`define TTM_REGS_VH

// Register byte offsets.
`define TTM_OFF_INTERVAL   12'h000
`define TTM_OFF_CURRENT    12'h004
`define TTM_OFF_AVERAGE    12'h008
`define TTM_OFF_LIMIT      12'h00C
`define TTM_OFF_STATUS     12'h010
`define TTM_OFF_CONTROL    12'h014
`define TTM_OFF_OVERRIDE   12'h018
`define TTM_OFF_SLEEP      12'h01C

// Status field positions.
`define TTM_ST_FULL        0
`define TTM_ST_P75         1
`define TTM_ST_P50         2
`define TTM_ST_P25         3
`define TTM_ST_P12         4
`define TTM_ST_P0          5
`define TTM_ST_ANY         6
`define TTM_ST_USER        7

// Control field positions.
`define TTM_CTL_OT_EN      0

// Sleep state encodings.
`define TTM_SLP_S0         2'h0
`define TTM_SLP_S3         2'h1
`define TTM_SLP_S45        2'h2

// Coarse thresholds on the 8-bit measurement.
`define TTM_TH_75          8'hC1
`define TTM_TH_50          8'h81
`define TTM_TH_25          8'h41
`define TTM_TH_12          8'h21

// Reset values.
`define TTM_RST_INTERVAL   32'h0001E848
`define TTM_RST_LIMIT      8'hFF
`define TTM_RST_CONTROL    1'b1

// Over-temperature response limit, in nanoseconds, and derived cycle count.
`define TTM_CLK_NS         8
`define TTM_OT_RESP_NS     10000
`define TTM_OT_RESP_CYC    (`TTM_OT_RESP_NS / `TTM_CLK_NS)

`endif

// File: design/ttm_duty_scale.v
// Scales an asserted-cycle count against an interval length to an 8-bit duty value.
// Assumes the interval is at least one cycle; combinational, used once per interval end.
`timescale 1ns/1ps
`default_nettype none

module ttm_duty_scale #(
  parameter CW = 32
) (
  // Count and interval.
  input  wire [CW-1:0] hits_i,
  input  wire [CW-1:0] span_i,
  // Scaled result.
  output reg  [7:0]    duty_o
);

  reg [CW+7:0] num;
  reg [CW+7:0] quo;

  // Ceiling of hits*256/span so any nonzero count gives at least one; capped at 255.
  always @* begin
    num = {hits_i, 8'h00};
    quo = (num + {8'h00, span_i} - {{(CW+7){1'b0}}, 1'b1}) / {8'h00, span_i};
    if (hits_i == {CW{1'b0}})
      duty_o = 8'h00;
    else if (quo > {{CW{1'b0}}, 8'hFF})
      duty_o = 8'hFF;
    else
      duty_o = quo[7:0];
  end

endmodule // ttm_duty_scale

`default_nettype wire

// File: bench/ttm_mon_chk.sv
// Port checker for ttm_monitor, bound to it below.
// Assumes APB writes land in the access cycle, so shadows can follow them.
`timescale 1ns/1ps
`default_nettype none
`include "ttm_regs.vh"
module ttm_mon_chk (
  // Clock, reset and APB.
  input wire logic        MCLK_I,
  input wire logic        RST_N_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  // Throttle and regulator pins.
  input wire logic        THERMAL_THROTTLE_LINE_O,
  input wire logic        THERMAL_THROTTLE_LINE_OE_N_O,
  input wire logic        REGULATOR_OVERTEMP_INPUT_N_I
);
  logic en_q;
  logic slp_q;
  logic ovr_q;
  wire  rd_s = PSEL_I && !PENABLE_I && !PWRITE_I;
  wire  hot  = !REGULATOR_OVERTEMP_INPUT_N_I && en_q && !slp_q && !ovr_q;
  wire  calm = !ovr_q && (REGULATOR_OVERTEMP_INPUT_N_I || !en_q || slp_q);
  // Shadows of the drive controls, so no hierarchy is needed.
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      en_q  <= `TTM_RST_CONTROL;
      slp_q <= 1'b0;
      ovr_q <= 1'b0;
    end else if (PSEL_I && PENABLE_I && PWRITE_I) begin
      if (PADDR_I == `TTM_OFF_CONTROL) en_q <= PWDATA_I[0];
      if (PADDR_I == `TTM_OFF_SLEEP) slp_q <= |PWDATA_I[1:0];
      if (PADDR_I == `TTM_OFF_OVERRIDE) ovr_q <= PWDATA_I[8];
    end
  end
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);
  sequence s_hot; hot [*4]; endsequence
  sequence s_calm; calm [*4]; endsequence
  property p_rdy; PSEL_I && PENABLE_I |-> PREADY_O; endproperty
  a_rdy: assert property (p_rdy) else $error("pready low in access");
  property p_err; PSEL_I && PENABLE_I |-> !PSLVERR_O; endproperty
  a_err: assert property (p_err) else $error("error response seen");
  property p_od; THERMAL_THROTTLE_LINE_O == 1'b0; endproperty
  a_od: assert property (p_od) else $error("line data not low");
  property p_hot; s_hot |-> !THERMAL_THROTTLE_LINE_OE_N_O; endproperty
  a_hot: assert property (p_hot) else $error("hot regulator not driven");
  property p_calm; s_calm |-> THERMAL_THROTTLE_LINE_OE_N_O; endproperty
  a_calm: assert property (p_calm) else $error("line pulled without cause");
  property p_unm; rd_s && PADDR_I == 12'h020 |=> PRDATA_O == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_hi; rd_s && PADDR_I == `TTM_OFF_STATUS |=> PRDATA_O[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("status upper bits set");
  property p_stand; !rd_s |=> $stable(PRDATA_O); endproperty
  a_stand: assert property (p_stand) else $error("read data moved");
endmodule // ttm_mon_chk
bind ttm_monitor ttm_mon_chk ttm_mon_chk_inst (.MCLK_I, .RST_N_I, .PSEL_I, .PENABLE_I,
  .PWRITE_I, .PADDR_I, .PWDATA_I, .PRDATA_O, .PREADY_O, .PSLVERR_O,
  .THERMAL_THROTTLE_LINE_O, .THERMAL_THROTTLE_LINE_OE_N_O, .REGULATOR_OVERTEMP_INPUT_N_I);
`default_nettype wire

// File: bench/ttm_cpu_model.sv
// Processor side of the throttle line: pulls it low on request.
// Assumes an open-drain line with a pull-up resolved by the bench.
`timescale 1ns/1ps
`default_nettype none
module ttm_cpu_model #(
  parameter int MIN_HOLD = 23375
) (
  input  wire logic clk_i,
  input  wire logic req_i,
  output var  logic oe_n_o
);
  int held_q = 0;
  initial oe_n_o = 1'b1;
  // Each assertion lasts at least MIN_HOLD cycles, like the real part.
  always @(posedge clk_i) begin
    if (req_i || (!oe_n_o && held_q < MIN_HOLD)) begin
      oe_n_o <= 1'b0;
      held_q <= held_q + 1;
    end else begin
      oe_n_o <= 1'b1;
      held_q <= 0;
    end
  end
endmodule // ttm_cpu_model
`default_nettype wire

// File: bench/tb_ttm_monitor.sv
// Bench for ttm_monitor: APB tasks, processor model and pull-up line.
// Assumes a 256-cycle interval, so each sampled low cycle is one LSB.
`timescale 1ns/1ps
`default_nettype none
`include "ttm_regs.vh"
module tb_ttm_monitor;
  logic        clk, rst_n, psel, pen, pwr, reg_n, req, first_m;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [7:0]  cur_m, avg_m, lim_m;
  wire  [31:0] prdata;
  wire         pready, dev_o, oe_n, cpu_n;
  int          n_fail, checks_done, lo_cnt;
  int          cycles = 0;
  int          ks[10] = '{0, 1, 32, 33, 64, 65, 128, 129, 192, 193};
  // Open-drain line with a pull-up: low when either side pulls.
  wire         line_n = (oe_n | dev_o) & cpu_n;
  ttm_monitor ttm_monitor_inst (.MCLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(), .THERMAL_THROTTLE_LINE_N_I(line_n), .THERMAL_THROTTLE_LINE_O(dev_o),
    .THERMAL_THROTTLE_LINE_OE_N_O(oe_n), .REGULATOR_OVERTEMP_INPUT_N_I(reg_n));
  ttm_cpu_model #(.MIN_HOLD(1)) ttm_cpu_model_inst (.clk_i(clk), .req_i(req), .oe_n_o(cpu_n));
  // Free-running 125 MHz clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // A hang costs far more cycles than the whole run needs.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail = n_fail + 1;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // Restart an interval, pull the line k cycles, then check all results.
  task automatic meas(input int k, input logic full);
    logic [7:0] v;
    logic [8:0] t;
    logic [7:0] p;
    p = cur_m;
    v = full ? 8'hFF : k[7:0];
    t = avg_m + cur_m;
    avg_m = first_m ? v : t[8:1];
    cur_m = v;
    first_m = 1'b0;
    @(posedge clk);
    req <= full;
    // Rewrite the held value: the restart must not disturb the next average.
    apb(1'b1, `TTM_OFF_CURRENT, {24'h0, p});
    repeat (8) @(posedge clk);
    if (k > 0) begin
      req <= 1'b1;
      repeat (k) @(posedge clk);
      req <= 1'b0;
    end
    repeat (272 - k) @(posedge clk);
    rdc(`TTM_OFF_CURRENT, {24'h0, v});
    rdc(`TTM_OFF_AVERAGE, {24'h0, avg_m});
    rdc(`TTM_OFF_STATUS, {24'h0, v > lim_m, v > 0, v > 0 && v < 33, v >= 33 && v < 65,
      v >= 65 && v < 129, v >= 129 && v < 193, v >= 193 && !full, full});
    req <= 1'b0;
    $display("measure k=%0d full=%0d done", k, full);
  endtask
  // Sleep with a hot regulator, set the interval, then wake.
  task automatic slp(input logic [1:0] code);
    apb(1'b1, `TTM_OFF_SLEEP, {30'h0, code});
    apb(1'b1, `TTM_OFF_INTERVAL, 32'h100);
    reg_n <= 1'b0;
    repeat (10) @(posedge clk);
    #1;
    chk({31'h0, line_n}, 32'h1);
    rdc(`TTM_OFF_CURRENT, 32'h0);
    rdc(`TTM_OFF_AVERAGE, {24'h0, avg_m});
    reg_n <= 1'b1;
    apb(1'b1, `TTM_OFF_SLEEP, {30'h0, `TTM_SLP_S0});
    first_m = 1'b1;
    $display("sleep %0d done", code);
  endtask
  task automatic ot(input logic en);
    apb(1'b1, `TTM_OFF_CONTROL, {31'h0, en});
    reg_n <= 1'b0;
    repeat (10) @(posedge clk);
    #1;
    chk({31'h0, line_n}, {31'h0, !en});
    @(posedge clk);
    reg_n <= 1'b1;
    repeat (10) @(posedge clk);
    #1;
    chk({31'h0, line_n}, 32'h1);
    $display("overtemp en=%0d done", en);
  endtask
  // Main sequence.
  initial begin
    {psel, pen, pwr, req, rst_n, first_m} = 6'h00;
    reg_n = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0;
    {cur_m, avg_m} = 16'h0000;
    lim_m = `TTM_RST_LIMIT;
    n_fail = 0;
    checks_done = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rdc(`TTM_OFF_INTERVAL, `TTM_RST_INTERVAL);
    rdc(`TTM_OFF_LIMIT, {24'h0, `TTM_RST_LIMIT});
    rdc(`TTM_OFF_CONTROL, {31'h0, `TTM_RST_CONTROL});
    apb(1'b1, 12'h020, 32'h5A5A5A5A);
    rdc(12'h020, 32'h0);
    apb(1'b1, `TTM_OFF_AVERAGE, 32'hAA);
    rdc(`TTM_OFF_AVERAGE, 32'h0);
    ot(1'b0);
    ot(1'b1);
    apb(1'b1, `TTM_OFF_OVERRIDE, 32'h140);
    repeat (300) @(posedge clk);
    lo_cnt = 0;
    repeat (256) @(negedge clk) lo_cnt = lo_cnt + !line_n;
    chk(lo_cnt, 32'h40);
    apb(1'b1, `TTM_OFF_OVERRIDE, 32'h0);
    slp(`TTM_SLP_S3);
    foreach (ks[i]) meas(ks[i], 1'b0);
    meas(0, 1'b1);
    apb(1'b1, `TTM_OFF_LIMIT, 32'h64);
    lim_m = 8'h64;
    meas(100, 1'b0);
    meas(101, 1'b0);
    slp(`TTM_SLP_S45);
    meas(50, 1'b0);
    complete_run();
  end
endmodule // tb_ttm_monitor
`default_nettype wire
